//--- design/counter_cmd_defs.svh
`ifndef COUNTER_CMD_DEFS_SVH
`define COUNTER_CMD_DEFS_SVH

// Widths and counts.
`define CMD_W        8
`define NUM_CTR      5
`define CTR_W        16

// Command byte field positions.
`define OP_HI        7
`define OP_LO        5
`define SUB_HI       4
`define SUB_LO       3
`define MASK_HI      4
`define NUM_HI       2
`define ELEM_HI      4
`define ELEM_LO      3
`define GRP_HI       2

// Top three bits of the command byte.
`define OP_PTR       3'h0
`define OP_ARM       3'h1
`define OP_LOAD      3'h2
`define OP_LDARM     3'h3
`define OP_DSAVE     3'h4
`define OP_SAVE      3'h5
`define OP_DISARM    3'h6

// Bits 4:3 of the single-counter and master-mode commands.
`define SUB_CLR      2'h0
`define SUB_SET      2'h1
`define SUB_STEP     2'h2
`define SUB_MISC     2'h3

// Low three bits that pick a master-mode or miscellaneous action.
`define N_POINTER_SEQUENCING_DISABLE       3'h0
`define N_FREQ_OUT_GATE_OFF       3'h6
`define N_WIDE_BUS_SELECT       3'h7
`define N_PF_ON      3'h0
`define N_PF_OFF     3'h1
`define N_MRESET     3'h7
`define N_FIRST      3'h1
`define N_LAST       3'h5

// Group values that never reach the pointer.
`define GRP_BAD0     3'h0
`define GRP_BAD1     3'h6

// Reset values and counting constants.
`define RST_BIT      1'h0
`define RST_ELEM     2'h0
`define RST_GRP      3'h1
`define RST_CNT      16'h0000
`define CNT_ONE      16'h0001
`define CNT_PRE_DOWN 16'h0001
`define CNT_PRE_UP   16'hFFFF

`endif

//--- design/counter_cmd_pkg.sv
`include "counter_cmd_defs.svh"

package counter_cmd_pkg;

  // Decoded command kinds.
  typedef enum logic [4:0] {
    k_none, k_ptr, k_arm, k_load, k_ldarm, k_dsave, k_save, k_disarm,
    k_set_tog, k_clr_tog, k_step, k_pointer_sequencing_disable_set, k_pointer_sequencing_disable_clr, k_freq_out_gate_off_set,
    k_freq_out_gate_off_clr, k_wide_bus_select_set, k_wide_bus_select_clr, k_pf_on, k_pf_off, k_mreset
  } cmd_kind_t;

  // True when a counter number names one of the five counters.
  function automatic logic ctr_valid(input logic [2:0] n);
    ctr_valid = (n >= `N_FIRST) && (n <= `N_LAST);
  endfunction : ctr_valid

  // One-hot select for a counter number; invalid numbers give no bit.
  function automatic logic [`NUM_CTR-1:0] ctr_onehot(input logic [2:0] n);
    ctr_onehot = '0;
    for (int i = 0; i < `NUM_CTR; i++) begin
      ctr_onehot[i] = (n == 3'(i + 1));
    end
  endfunction : ctr_onehot

endpackage : counter_cmd_pkg

//--- design/cmd_field_decode.sv
`timescale 1ns/100ps
`include "counter_cmd_defs.svh"
module cmd_field_decode (
  // Latched command.
  input  wire logic                        cmd_valid,
  input  wire logic [`CMD_W-1:0]           cmd_byte,
  // Decoded action.
  output counter_cmd_pkg::cmd_kind_t       cmd_kind,
  output logic      [`NUM_CTR-1:0]         ctr_sel
);
  import counter_cmd_pkg::*;

  // Splits the byte into its fields and names the command.
  function automatic cmd_kind_t kind_of(input logic [`CMD_W-1:0] b);
    logic [2:0] op;
    logic [1:0] sub;
    logic [2:0] n;
    op  = b[`OP_HI:`OP_LO];
    sub = b[`SUB_HI:`SUB_LO];
    n   = b[`NUM_HI:0];
    case (op)
      `OP_PTR:    kind_of = (n == `GRP_BAD0 || n == `GRP_BAD1) ? k_none : k_ptr;
      `OP_ARM:    kind_of = k_arm;
      `OP_LOAD:   kind_of = k_load;
      `OP_LDARM:  kind_of = k_ldarm;
      `OP_DSAVE:  kind_of = k_dsave;
      `OP_SAVE:   kind_of = k_save;
      `OP_DISARM: kind_of = k_disarm;
      default: begin
        case (sub)
          `SUB_SET: kind_of = (n == `N_POINTER_SEQUENCING_DISABLE) ? k_pointer_sequencing_disable_set :
                              (n == `N_FREQ_OUT_GATE_OFF) ? k_freq_out_gate_off_set :
                              (n == `N_WIDE_BUS_SELECT) ? k_wide_bus_select_set :
                              ctr_valid(n)   ? k_set_tog  : k_none;
          `SUB_CLR: kind_of = (n == `N_POINTER_SEQUENCING_DISABLE) ? k_pointer_sequencing_disable_clr :
                              (n == `N_FREQ_OUT_GATE_OFF) ? k_freq_out_gate_off_clr :
                              (n == `N_WIDE_BUS_SELECT) ? k_wide_bus_select_clr :
                              ctr_valid(n)   ? k_clr_tog  : k_none;
          `SUB_STEP: kind_of = ctr_valid(n) ? k_step : k_none;
          default:  kind_of = (n == `N_PF_ON)  ? k_pf_on  :
                              (n == `N_PF_OFF) ? k_pf_off :
                              (n == `N_MRESET) ? k_mreset : k_none;
        endcase
      end
    endcase
  endfunction : kind_of

  // Mask commands use the low five bits, single-counter ones the number.
  wire             op_single = (cmd_byte[`OP_HI:`OP_LO] == 3'h7);
  assign cmd_kind = cmd_valid ? kind_of(cmd_byte) : k_none;
  assign ctr_sel  = op_single ? ctr_onehot(cmd_byte[`NUM_HI:0]) : cmd_byte[`MASK_HI:0];

endmodule : cmd_field_decode

//--- design/counter_slice.sv
`timescale 1ns/100ps
`include "counter_cmd_defs.svh"
module counter_slice #(
  parameter int W = `CTR_W
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // Command strobes for this counter.
  input  wire logic         do_arm,
  input  wire logic         do_load,
  input  wire logic         do_disarm,
  input  wire logic         do_save,
  input  wire logic         do_step,
  input  wire logic         do_set_tog,
  input  wire logic         do_clr_tog,
  input  wire logic         mreset,
  // Counting context.
  input  wire logic         src_edge,
  input  wire logic         hw_gate_ok,
  input  wire logic         dir_up,
  input  wire logic         alt_mode,
  input  wire logic         gate_mode,
  input  wire logic         gate_level,
  input  wire logic         load_wr,
  input  wire logic [W-1:0] load_data,
  // Counter state.
  output logic      [W-1:0] count,
  output logic      [W-1:0] hold,
  output logic      [W-1:0] load_reg,
  output logic              armed,
  output logic              tc,
  output logic              toggle,
  output logic              sel_hold
);
  logic pending;

  // Count pulses: armed and gated source edges, the edge that leaves TC, steps and loads.
  wire         src_pulse = src_edge & ((armed & hw_gate_ok) | tc);
  wire         cnt_pulse = src_pulse | do_step | do_load;
  wire [W-1:0] pre_tc    = dir_up ? W'(`CNT_PRE_UP) : W'(`CNT_PRE_DOWN);
  wire [W-1:0] stepped   = dir_up ? count + W'(`CNT_ONE) : count - W'(`CNT_ONE);
  wire         load_in_tc = do_load & tc;
  wire         enter_tc  = cnt_pulse & (count == pre_tc) & ~load_in_tc;
  wire         leave_tc  = tc & cnt_pulse;
  // Reload source as a terminal count would pick it.
  wire         src_hold  = gate_mode ? gate_level : (alt_mode & sel_hold);
  // Source when a load ends TC: disarmed counters outside gate mode take the load register.
  wire         tc_hold   = gate_mode ? gate_level : (armed & alt_mode & sel_hold);
  wire [W-1:0] reload    = src_hold ? hold : load_reg;
  wire [W-1:0] tc_reload = tc_hold ? hold : load_reg;
  wire         disarm_now = do_disarm & ~(tc & ~cnt_pulse);

  wire [W-1:0] next_count = enter_tc   ? reload :
                            load_in_tc ? tc_reload :
                            do_load    ? reload :
                            cnt_pulse  ? stepped : count;
  wire         next_tc    = enter_tc | (tc & ~cnt_pulse);
  // Arm resets the selector after any flip from a load-driven TC.
  wire         next_sel   = do_arm ? 1'h1 : (enter_tc & alt_mode) ? ~sel_hold : sel_hold;
  wire         next_armed = do_arm ? 1'h1 : (disarm_now | (pending & leave_tc)) ? 1'h0 : armed;
  wire         next_pend  = do_arm ? 1'h0 : (do_disarm & tc & ~cnt_pulse) ? 1'h1 :
                            leave_tc ? 1'h0 : pending;
  wire         next_tog   = do_set_tog ? 1'h1 : do_clr_tog ? 1'h0 : toggle ^ enter_tc;

  // Counter value, TC state and reload selector.
  always_ff @(posedge sys_clk) begin
    if (!nrst || mreset) begin
      count    <= `RST_CNT;
      tc       <= `RST_BIT;
      sel_hold <= `RST_BIT;
    end else begin
      count    <= next_count;
      tc       <= next_tc;
      sel_hold <= next_sel;
    end
  end

  // Arm state, deferred disarm, toggle output and the load and hold registers.
  always_ff @(posedge sys_clk) begin
    if (!nrst || mreset) begin
      armed    <= `RST_BIT;
      pending  <= `RST_BIT;
      toggle   <= `RST_BIT;
      hold     <= `RST_CNT;
      load_reg <= `RST_CNT;
    end else begin
      armed    <= next_armed;
      pending  <= next_pend;
      toggle   <= next_tog;
      hold     <= do_save ? count : hold;
      load_reg <= load_wr ? load_data : load_reg;
    end
  end

endmodule : counter_slice

//--- design/counter_command_decoder.sv
// Functional notes
// - Each host byte on the control port is latched and decoded as a command.
// - Mask commands act on every counter whose low-five-bit select is set, together.
// - Single-counter commands use the low three bits as counter number one to five.
// - Top bits 001 arm, 010 load, 011 load-arm, 100 disarm-save, 101 save, 110 disarm.
// - Top bits 000 load pointer element from bits 4:3, group from 2:0.
// - Code 11101 n sets counter n toggle; 11100 n clears it.
// - Code 11110 n steps counter n by one count.
// - Master-mode codes set or clear sequencing disable, output gate and bus width.
// - Codes enable or disable write prefetch; all ones does a master reset.
// - Arm enables counting; zero mask bits leave arm state unchanged.
// - Unarmed counters take no source edge except the one leaving TC; hardware gate further qualifies armed ones.
// - Disarm in TC waits until the counter leaves TC.
// - Arm or load-arm resets alternating reload selector to hold first.
// - Load copies load or hold register into counter, any arm state.
// - Load is a pseudo-count; one count before TC it enters TC.
// - Load in TC ends TC; armed counters reload from planned source.
// - Disarmed counter loaded in TC reloads from the load register unless gate-selected.
// - Gate-selected modes pick reload source from the gate level.
// - Load-driven TC flips the alternating selector like a source edge.
// - Load during TC ends it without flipping the selector.
// - Step decrements or increments by direction bit, even when disarmed.
// - Save copies counter value into hold register without disturbing counting.
// - Load-and-arm equals load then arm on the same counters.
`timescale 1ns/100ps
`include "counter_cmd_defs.svh"
module counter_command_decoder #(
  parameter int N = `NUM_CTR,
  parameter int W = `CTR_W
) (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Control port from the host.
  input  wire logic                 cmd_wr,
  input  wire logic [`CMD_W-1:0]    cmd_data,
  // Load register writes.
  input  wire logic [N-1:0]         load_wr,
  input  wire logic [W-1:0]         load_data,
  // Per-counter counting context.
  input  wire logic [N-1:0]         src_edge,
  input  wire logic [N-1:0]         hw_gate_ok,
  input  wire logic [N-1:0]         count_direction_bit,
  input  wire logic [N-1:0]         alt_reload_mode,
  input  wire logic [N-1:0]         gate_reload_mode,
  input  wire logic [N-1:0]         gate_level,
  // Master-mode bits and pointer.
  output logic                      pointer_sequencing_disable,
  output logic                      freq_out_gate_off,
  output logic                      wide_bus_select,
  output logic                      write_prefetch_en,
  output logic      [1:0]           element_field,
  output logic      [2:0]           group_field,
  output logic                      byte_pointer,
  // Counter state.
  output logic      [N-1:0][W-1:0]  count_value,
  output logic      [N-1:0][W-1:0]  hold_value,
  output logic      [N-1:0][W-1:0]  load_value,
  output logic      [N-1:0]         armed,
  output logic      [N-1:0]         terminal_count_state,
  output logic      [N-1:0]         toggle_out,
  output logic      [N-1:0]         reload_sel_hold
);
  import counter_cmd_pkg::*;

  logic [`CMD_W-1:0] command_register;
  logic              cmd_valid;
  cmd_kind_t         cmd_kind;
  logic [N-1:0]      ctr_sel;

  // Command register and its one-cycle decode strobe.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      command_register <= '0;
      cmd_valid        <= `RST_BIT;
    end else begin
      command_register <= cmd_wr ? cmd_data : command_register;
      cmd_valid        <= cmd_wr;
    end
  end

  cmd_field_decode u_decode (
    .cmd_valid (cmd_valid),
    .cmd_byte  (command_register),
    .cmd_kind  (cmd_kind),
    .ctr_sel   (ctr_sel)
  );

  // Per-counter strobes from the kind and the select; unused codes give none.
  wire         mreset   = (cmd_kind == k_mreset);
  wire [N-1:0] arm_s    = ((cmd_kind == k_arm) || (cmd_kind == k_ldarm)) ? ctr_sel : '0;
  wire [N-1:0] load_s   = ((cmd_kind == k_load) || (cmd_kind == k_ldarm)) ? ctr_sel : '0;
  wire [N-1:0] disarm_s = ((cmd_kind == k_disarm) || (cmd_kind == k_dsave)) ? ctr_sel : '0;
  wire [N-1:0] save_s   = ((cmd_kind == k_save) || (cmd_kind == k_dsave)) ? ctr_sel : '0;
  wire [N-1:0] step_s   = (cmd_kind == k_step) ? ctr_sel : '0;
  wire [N-1:0] set_s    = (cmd_kind == k_set_tog) ? ctr_sel : '0;
  wire [N-1:0] clr_s    = (cmd_kind == k_clr_tog) ? ctr_sel : '0;

  // Next values of the master-mode bits; codes not listed hold them.
  wire next_seq_dis = (cmd_kind == k_pointer_sequencing_disable_set) ? 1'h1 :
                      (cmd_kind == k_pointer_sequencing_disable_clr) ? 1'h0 : pointer_sequencing_disable;
  wire next_frequency_output    = (cmd_kind == k_freq_out_gate_off_set) ? 1'h1 :
                      (cmd_kind == k_freq_out_gate_off_clr) ? 1'h0 : freq_out_gate_off;
  wire next_wide    = (cmd_kind == k_wide_bus_select_set) ? 1'h1 :
                      (cmd_kind == k_wide_bus_select_clr) ? 1'h0 : wide_bus_select;
  wire next_pf      = (cmd_kind == k_pf_on)  ? 1'h1 :
                      (cmd_kind == k_pf_off) ? 1'h0 : write_prefetch_en;
  wire ptr_ld       = (cmd_kind == k_ptr);

  // Master-mode bits.
  always_ff @(posedge sys_clk) begin
    if (!nrst || mreset) begin
      pointer_sequencing_disable <= `RST_BIT;
      freq_out_gate_off          <= `RST_BIT;
      wide_bus_select            <= `RST_BIT;
      write_prefetch_en          <= `RST_BIT;
    end else begin
      pointer_sequencing_disable <= next_seq_dis;
      freq_out_gate_off          <= next_frequency_output;
      wide_bus_select            <= next_wide;
      write_prefetch_en          <= next_pf;
    end
  end

  // Pointer element and group fields; loading also sets the byte pointer.
  always_ff @(posedge sys_clk) begin
    if (!nrst || mreset) begin
      element_field <= `RST_ELEM;
      group_field   <= `RST_GRP;
      byte_pointer  <= `RST_BIT;
    end else if (ptr_ld) begin
      element_field <= command_register[`ELEM_HI:`ELEM_LO];
      group_field   <= command_register[`GRP_HI:0];
      byte_pointer  <= 1'h1;
    end
  end

  // One slice per counter; all selected slices act on the same edge.
  for (genvar i = 0; i < N; i++) begin : g_ctr
    counter_slice #(
      .W (W)
    ) u_slice (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .do_arm     (arm_s[i]),
      .do_load    (load_s[i]),
      .do_disarm  (disarm_s[i]),
      .do_save    (save_s[i]),
      .do_step    (step_s[i]),
      .do_set_tog (set_s[i]),
      .do_clr_tog (clr_s[i]),
      .mreset     (mreset),
      .src_edge   (src_edge[i]),
      .hw_gate_ok (hw_gate_ok[i]),
      .dir_up     (count_direction_bit[i]),
      .alt_mode   (alt_reload_mode[i]),
      .gate_mode  (gate_reload_mode[i]),
      .gate_level (gate_level[i]),
      .load_wr    (load_wr[i]),
      .load_data  (load_data),
      .count      (count_value[i]),
      .hold       (hold_value[i]),
      .load_reg   (load_value[i]),
      .armed      (armed[i]),
      .tc         (terminal_count_state[i]),
      .toggle     (toggle_out[i]),
      .sel_hold   (reload_sel_hold[i])
    );
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Command latch and decode strobe.
  a_cmd_latch: assert property (
    cmd_wr |=> cmd_valid && command_register == $past(cmd_data))
    else $error("command byte not latched");

  // Pointer load from a valid group, and unused codes leave state alone.
  a_ptr_load: assert property (
    cmd_valid && ptr_ld |=> element_field == $past(command_register[`ELEM_HI:`ELEM_LO])
      && group_field == $past(command_register[`GRP_HI:0]) && byte_pointer)
    else $error("pointer fields not loaded");

  a_unused_idle: assert property (
    cmd_valid && cmd_kind == k_none |=> $stable(element_field) && $stable(group_field)
      && $stable(pointer_sequencing_disable) && $stable(wide_bus_select)
      && $stable(freq_out_gate_off) && $stable(write_prefetch_en) && $stable(armed))
    else $error("unused code changed state");

  // Master-mode set and clear codes.
  a_mm_bits: assert property (
    (cmd_kind == k_pointer_sequencing_disable_set |=> pointer_sequencing_disable) and
    (cmd_kind == k_freq_out_gate_off_set |=> freq_out_gate_off) and
    (cmd_kind == k_wide_bus_select_clr |=> !wide_bus_select))
    else $error("master mode bit wrong");

  // Prefetch enable, and master reset clearing the counters.
  a_prefetch_reset: assert property (
    (cmd_kind == k_pf_on |=> write_prefetch_en) and
    (cmd_kind == k_mreset |=> armed == '0 && terminal_count_state == '0 && !wide_bus_select))
    else $error("prefetch or master reset wrong");

  for (genvar i = 0; i < N; i++) begin : g_chk
    // Disarm and save observed together on the cycle after the command.
    sequence s_dsave_issue;
      cmd_kind == k_dsave && ctr_sel[i] && !terminal_count_state[i];
    endsequence
    sequence s_dsave_done;
      !armed[i] && hold_value[i] == $past(count_value[i]);
    endsequence
    // Load-and-arm leaves the counter armed with hold as next source.
    sequence s_ldarm_issue;
      cmd_kind == k_ldarm && ctr_sel[i];
    endsequence

    a_mask_skip: assert property (
      cmd_kind == k_save && !ctr_sel[i] |=> $stable(hold_value[i]))
      else $error("unselected counter saved");

    a_arm_sets: assert property (
      cmd_kind == k_arm && ctr_sel[i] |=> armed[i] ##1 (armed[i] || $past(cmd_valid)))
      else $error("arm did not take");

    a_unarmed_idle: assert property (
      !armed[i] && !terminal_count_state[i] && !cmd_valid |=> $stable(count_value[i]))
      else $error("unarmed counter moved");

    a_step_only: assert property (
      cmd_kind == k_step && !ctr_sel[i] && !src_edge[i] |=> $stable(count_value[i]))
      else $error("step hit wrong counter");

    a_step_moves: assert property (
      cmd_kind == k_step && ctr_sel[i] && !terminal_count_state[i]
        && count_value[i] != (count_direction_bit[i] ? W'(`CNT_PRE_UP) : W'(`CNT_PRE_DOWN))
      |=> count_value[i] == ($past(count_direction_bit[i]) ? $past(count_value[i]) + W'(`CNT_ONE)
                                                   : $past(count_value[i]) - W'(`CNT_ONE)))
      else $error("step count wrong");

    a_toggle_cmd: assert property (
      (cmd_kind == k_set_tog && ctr_sel[i] |=> toggle_out[i]) and
      (cmd_kind == k_clr_tog && ctr_sel[i] |=> !toggle_out[i]))
      else $error("toggle command wrong");

    a_defer_disarm: assert property (
      cmd_kind == k_disarm && ctr_sel[i] && terminal_count_state[i] && !src_edge[i]
      |=> armed[i] == $past(armed[i]) && terminal_count_state[i])
      else $error("disarm not deferred in TC");

    a_arm_sel: assert property (
      cmd_kind == k_arm && ctr_sel[i] |=> reload_sel_hold[i])
      else $error("arm did not reset selector");

    a_load_copy: assert property (
      cmd_kind == k_load && ctr_sel[i] && !terminal_count_state[i]
        && !alt_reload_mode[i] && !gate_reload_mode[i]
      |=> count_value[i] == $past(load_value[i]))
      else $error("load did not copy load register");

    a_load_into_tc: assert property (
      cmd_kind == k_load && ctr_sel[i] && !terminal_count_state[i]
        && count_value[i] == (count_direction_bit[i] ? W'(`CNT_PRE_UP) : W'(`CNT_PRE_DOWN))
      |=> terminal_count_state[i])
      else $error("load before TC missed TC");

    a_load_in_tc: assert property (
      cmd_kind == k_load && ctr_sel[i] && terminal_count_state[i]
      |=> !terminal_count_state[i] && reload_sel_hold[i] == $past(reload_sel_hold[i]))
      else $error("load in TC wrong");

    a_disarmed_reload: assert property (
      cmd_kind == k_load && ctr_sel[i] && terminal_count_state[i] && !armed[i]
        && !gate_reload_mode[i] |=> count_value[i] == $past(load_value[i]))
      else $error("disarmed TC load not from load register");

    a_gate_reload: assert property (
      cmd_kind == k_load && ctr_sel[i] && gate_reload_mode[i] && !terminal_count_state[i]
      |=> count_value[i] == ($past(gate_level[i]) ? $past(hold_value[i]) : $past(load_value[i])))
      else $error("gate did not pick reload source");

    a_load_tc_flip: assert property (
      cmd_kind == k_load && ctr_sel[i] && alt_reload_mode[i] && !gate_reload_mode[i]
        && !terminal_count_state[i]
        && count_value[i] == (count_direction_bit[i] ? W'(`CNT_PRE_UP) : W'(`CNT_PRE_DOWN))
      |=> reload_sel_hold[i] != $past(reload_sel_hold[i]))
      else $error("load-driven TC did not flip selector");

    a_save_hold: assert property (
      s_dsave_issue |=> s_dsave_done)
      else $error("disarm and save wrong");

    a_ldarm_both: assert property (
      s_ldarm_issue |=> armed[i] && reload_sel_hold[i])
      else $error("load and arm not armed");
  end

endmodule : counter_command_decoder

//--- test/host_model.sv
`timescale 1ns/100ps
module host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Control port.
  output logic            cmd_wr,
  output logic [7:0]      cmd_data
);
  // The port starts idle.
  initial begin
    cmd_wr   = 1'b0;
    cmd_data = 8'h00;
  end

  // One whole byte per strobe, then wait out the two-edge decode latency.
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk);
    cmd_wr   = 1'b1;
    cmd_data = b;
    @(negedge sys_clk);
    cmd_wr   = 1'b0;
    cmd_data = ~b; // A released bus never shows the last byte.
    repeat (2) @(negedge sys_clk);
  endtask : send
endmodule : host_model

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import counter_cmd_pkg::*;
  logic             sys_clk = 1'b0;
  logic             nrst = 1'b0;
  logic             cmd_wr;
  logic [7:0]       cmd_data;
  logic [4:0]       load_wr = '0, src_edge = '0, gok = 5'h1F, alt = 5'h01;
  logic [4:0]       dir = '0, gmode = '0, glev = '0, tcs;
  logic [15:0]      load_data = '0;
  logic             psd, fog, wbs, wpe, bp;
  logic [1:0]       elem;
  logic [2:0]       grp;
  logic [4:0][15:0] cnt, hld, ldv;
  logic [4:0]       arm, tog, rsel;
  int               err_count = 0, checks = 0;
  logic [7:0]       mm_code [8] = '{8'hE8, 8'hEE, 8'hEF, 8'hF8, 8'hE0, 8'hE6, 8'hE7, 8'hF9};
  logic [3:0]       mm_exp [8] = '{4'h8, 4'hC, 4'hE, 4'hF, 4'h7, 4'h3, 4'h1, 4'h0};

  // Free-running clock, 4 ns period.
  always #2 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data));

  counter_command_decoder dut (.sys_clk(sys_clk), .nrst(nrst), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .load_wr(load_wr), .load_data(load_data), .src_edge(src_edge),
    .hw_gate_ok(gok), .count_direction_bit(dir), .alt_reload_mode(alt),
    .gate_reload_mode(gmode), .gate_level(glev), .pointer_sequencing_disable(psd),
    .freq_out_gate_off(fog), .wide_bus_select(wbs), .write_prefetch_en(wpe),
    .element_field(elem), .group_field(grp), .byte_pointer(bp), .count_value(cnt),
    .hold_value(hld), .load_value(ldv), .armed(arm), .terminal_count_state(tcs),
    .toggle_out(tog), .reload_sel_hold(rsel));

  // Compare one value and count it.
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One source edge pulse on the masked counters.
  task automatic pulse(input logic [4:0] m);
    @(negedge sys_clk);
    src_edge = m;
    @(negedge sys_clk);
    src_edge = '0;
    @(negedge sys_clk);
  endtask : pulse

  // One load register write on the masked counters.
  task automatic wload(input logic [4:0] m, input logic [15:0] d);
    @(negedge sys_clk);
    load_wr = m;
    load_data = d;
    @(negedge sys_clk);
    load_wr = '0;
  endtask : wload

  // Print the counts and the verdict, then stop.
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Main sequence of tests.
  initial begin
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    chk("group_field", 16'h0001, 16'(grp));
    host.send(8'h25);
    chk("armed", 16'h0005, 16'(arm));
    chk("reload_sel_hold", 16'h0005, 16'(rsel));
    host.send(8'h1A);
    chk("pointer", 16'h003A, 16'({bp, elem, grp}));
    host.send(8'h00);
    chk("pointer", 16'h003A, 16'({bp, elem, grp}));
    $display("test arm and pointer done");
    for (int i = 0; i < 8; i++) begin
      host.send(mm_code[i]);
      chk("master_mode", 16'(mm_exp[i]), 16'({psd, fog, wbs, wpe}));
    end
    host.send(8'hEB);
    chk("toggle_out", 16'h0004, 16'(tog));
    host.send(8'hE3);
    chk("toggle_out", 16'h0000, 16'(tog));
    $display("test modes done");
    wload(5'h02, 16'h0005);
    host.send(8'h42);
    chk("count_value", 16'h0005, cnt[1]);
    chk("load_value", 16'h0005, ldv[1]);
    host.send(8'hF2);
    chk("count_value", 16'h0004, cnt[1]);
    host.send(8'hA2);
    chk("hold_value", 16'h0004, hld[1]);
    pulse(5'h02);
    chk("count_value", 16'h0004, cnt[1]);
    host.send(8'h22);
    pulse(5'h02);
    chk("count_value", 16'h0003, cnt[1]);
    host.send(8'hFF);
    chk("count_value", 16'h0000, cnt[1]);
    chk("armed", 16'h0000, 16'(arm));
    $display("test counting done");
    wload(5'h09, 16'h0001);
    host.send(8'h49);
    chk("count_value", 16'h0001, cnt[3]);
    wload(5'h09, 16'h0006);
    host.send(8'h49);
    chk("terminal_count_state", 16'h0009, 16'(tcs));
    chk("count_value", 16'h0006, cnt[3]);
    chk("toggle_out", 16'h0009, 16'(tog));
    chk("reload_sel_hold", 16'h0001, 16'(rsel));
    host.send(8'h41);
    chk("terminal_count_state", 16'h0008, 16'(tcs));
    chk("count_value", 16'h0006, cnt[0]);
    chk("reload_sel_hold", 16'h0001, 16'(rsel));
    host.send(8'h28);
    host.send(8'hC8);
    chk("armed", 16'h0008, 16'(arm));
    gmode = 5'h08;
    glev = 5'h08;
    host.send(8'h48);
    chk("count_value", 16'h0000, cnt[3]);
    chk("armed", 16'h0000, 16'(arm));
    chk("terminal_count_state", 16'h0000, 16'(tcs));
    $display("test terminal count done");
    dir = 5'h04;
    host.send(8'hF3);
    chk("count_value", 16'h0001, cnt[2]);
    host.send(8'h24);
    gok = 5'h1B;
    pulse(5'h04);
    chk("count_value", 16'h0001, cnt[2]);
    gok = 5'h1F;
    pulse(5'h04);
    chk("count_value", 16'h0002, cnt[2]);
    $display("test up counting done");
    final_report();
  end

  // Watchdog far beyond the expected run length.
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule : testbench
